//--- common/vdp_pkg.sv
// Package with register map, field layout and reset values for the detector register slice
package vdp_pkg;
  // ----------------------------------------
  // Register offsets and pages
  // ----------------------------------------
  localparam logic [7:0] VDP_OFS_PAGE_SELECT  = 8'h00;
  localparam logic [7:0] VDP_OFS_VD_CONFIG_1  = 8'h1E;
  localparam logic [7:0] VDP_OFS_VD_CONFIG_2  = 8'h1F;
  localparam logic [7:0] VDP_OFS_CHECKSUM     = 8'h7E;
  localparam logic [7:0] VDP_OFS_POWER_CONFIG = 8'h75;
  localparam logic [7:0] VDP_PAGE_ZERO        = 8'h00;
  localparam logic [7:0] VDP_PAGE_ONE         = 8'h01;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] VDP_RST_PAGE_SELECT  = 8'h00;
  localparam logic [7:0] VDP_RST_VD_CONFIG_1  = 8'h20;
  localparam logic [7:0] VDP_RST_VD_CONFIG_2  = 8'h08;
  localparam logic [7:0] VDP_RST_CHECKSUM     = 8'h00;
  localparam logic [7:0] VDP_RST_POWER_CONFIG = 8'h00;
  localparam logic [7:0] VDP_RST_RD_DATA      = 8'h00;
  localparam logic [7:0] VDP_RD_UNMAPPED      = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int VDP_POS_POWER_SEQ  = 6;
  localparam int VDP_POS_CHANNEL    = 4;
  localparam int VDP_POS_CLK_SOURCE = 2;
  localparam int VDP_POS_CLK_RATE   = 0;
  localparam int VDP_POS_PIN_IRQ    = 6;
  localparam int VDP_POS_DET_REC    = 3;
  localparam int VDP_POS_DET_ENABLE = 0;
  // Writable bits of config two; bit 5 and bits 2-0 are read-only zero
  localparam logic [7:0] VDP_CFG2_WR_MASK = 8'hD8;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    VDP_SEQ_USER_BOTH   = 2'h0,
    VDP_SEQ_DET_BOTH    = 2'h1,
    VDP_SEQ_DET_UP_ONLY = 2'h2,
    VDP_SEQ_DET_DN_ONLY = 2'h3
  } vdp_power_seq_t;
  typedef enum logic [1:0] {
    VDP_CLK_INTERNAL = 2'h0,
    VDP_CLK_BIT_CLK  = 2'h1,
    VDP_CLK_MASTER   = 2'h2,
    VDP_CLK_CUSTOM   = 2'h3
  } vdp_clk_source_t;
endpackage

//--- rtl/vdp_regs.sv
// Register slice: write checksum, page select and voice detector configuration
`timescale 1ns/1ps
module vdp_regs
  import vdp_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_recording,
  input  wire logic       i_detector_irq,
  output logic      [7:0] o_rd_data,
  output logic      [7:0] o_page,
  output logic            o_detector_run,
  output logic      [1:0] o_power_seq,
  output logic      [1:0] o_channel_sel,
  output logic      [1:0] o_clock_source,
  output logic      [1:0] o_clock_rate,
  output logic            o_serial_out_irq,
  output logic            o_serial_out_irq_en
);

  // ----------------------------------------
  // Checksum function
  // ----------------------------------------
  // Rotate keeps byte order visible in the sum, unlike a plain XOR
  function automatic logic [7:0] vdp_fold(input logic [7:0] sum, input logic [7:0] data);
    vdp_fold = {sum[6:0], sum[7]} ^ data;
  endfunction

  function automatic logic vdp_hit(input logic [7:0] page, input logic [7:0] addr,
                                   input logic [7:0] want_page, input logic [7:0] want_ofs);
    vdp_hit = (page == want_page) && (addr == want_ofs);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] page_q;
  logic [7:0] page_d;
  logic [7:0] cfg_one_q;
  logic [7:0] cfg_one_d;
  logic [7:0] cfg_two_q;
  logic [7:0] cfg_two_d;
  logic [7:0] pwr_cfg_q;
  logic [7:0] pwr_cfg_d;
  logic [7:0] cksum_q;
  logic [7:0] cksum_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic       irq_pin_q;
  logic       irq_pin_d;
  logic       run_q;
  logic       run_d;

  logic       hit_page;
  logic       hit_one;
  logic       hit_two;
  logic       hit_pwr;
  logic       hit_sum;
  logic       wr_page;
  logic       wr_one;
  logic       wr_two;
  logic       wr_pwr;
  logic       wr_sum;

  vdp_power_seq_t  power_seq;
  vdp_clk_source_t clock_source;
  logic [1:0]      channel_sel;
  logic [1:0]      clock_rate;
  logic            pin_irq_en;
  logic            det_in_rec;
  logic            det_enable;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Page select answers on every page so the host can always leave a page
  always_comb begin
    hit_page = (i_addr == VDP_OFS_PAGE_SELECT);
    hit_one  = vdp_hit(page_q, i_addr, VDP_PAGE_ONE, VDP_OFS_VD_CONFIG_1);
    hit_two  = vdp_hit(page_q, i_addr, VDP_PAGE_ONE, VDP_OFS_VD_CONFIG_2);
    hit_pwr  = vdp_hit(page_q, i_addr, VDP_PAGE_ZERO, VDP_OFS_POWER_CONFIG);
    hit_sum  = vdp_hit(page_q, i_addr, VDP_PAGE_ZERO, VDP_OFS_CHECKSUM);
    wr_page  = i_wr_en && hit_page;
    wr_one   = i_wr_en && hit_one;
    wr_two   = i_wr_en && hit_two;
    wr_pwr   = i_wr_en && hit_pwr;
    wr_sum   = i_wr_en && hit_sum;
  end

  // ----------------------------------------
  // Page select
  // ----------------------------------------
  // Any page number is legal; unmapped pages decode only the page select
  always_comb begin
    if (wr_page) begin
      page_d = i_wr_data;
    end else begin
      page_d = page_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      page_q <= VDP_RST_PAGE_SELECT;
    end else begin
      page_q <= page_d;
    end
  end

  // ----------------------------------------
  // Detector config one
  // ----------------------------------------
  always_comb begin
    if (wr_one) begin
      cfg_one_d = i_wr_data;
    end else begin
      cfg_one_d = cfg_one_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cfg_one_q <= VDP_RST_VD_CONFIG_1;
    end else begin
      cfg_one_q <= cfg_one_d;
    end
  end

  // ----------------------------------------
  // Detector config two
  // ----------------------------------------
  // Read-only reserved bits stay zero whatever the host writes
  always_comb begin
    if (wr_two) begin
      cfg_two_d = i_wr_data & VDP_CFG2_WR_MASK;
    end else begin
      cfg_two_d = cfg_two_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cfg_two_q <= VDP_RST_VD_CONFIG_2;
    end else begin
      cfg_two_q <= cfg_two_d;
    end
  end

  // ----------------------------------------
  // Power config
  // ----------------------------------------
  // Only the detector enable is used here; the rest is kept for read-back
  always_comb begin
    if (wr_pwr) begin
      pwr_cfg_d = i_wr_data;
    end else begin
      pwr_cfg_d = pwr_cfg_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pwr_cfg_q <= VDP_RST_POWER_CONFIG;
    end else begin
      pwr_cfg_q <= pwr_cfg_d;
    end
  end

  // ----------------------------------------
  // Write checksum
  // ----------------------------------------
  // Reset clears the sum; the host seeds it by writing the register
  always_comb begin
    cksum_d = cksum_q;
    if (wr_sum) begin
      cksum_d = i_wr_data;
    end else if (i_wr_en) begin
      // Unmapped offsets still count as writes to the device
      cksum_d = vdp_fold(cksum_q, i_wr_data);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cksum_q <= VDP_RST_CHECKSUM;
    end else begin
      cksum_q <= cksum_d;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read data holds until the next read, so a slow host may fetch it late
  always_comb begin
    rd_data_d = rd_data_q;
    if (i_rd_en) begin
      if (hit_page) begin
        rd_data_d = page_q;
      end else if (hit_one) begin
        rd_data_d = cfg_one_q;
      end else if (hit_two) begin
        rd_data_d = cfg_two_q;
      end else if (hit_pwr) begin
        rd_data_d = pwr_cfg_q;
      end else if (hit_sum) begin
        rd_data_d = cksum_q;
      end else begin
        rd_data_d = VDP_RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rd_data_q <= VDP_RST_RD_DATA;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------
  // Field split
  // ----------------------------------------
  // Enum views keep the encodings in one place for later decoding
  always_comb begin
    power_seq    = vdp_power_seq_t'(cfg_one_q[VDP_POS_POWER_SEQ +: 2]);
    channel_sel  = cfg_one_q[VDP_POS_CHANNEL +: 2];
    clock_source = vdp_clk_source_t'(cfg_one_q[VDP_POS_CLK_SOURCE +: 2]);
    clock_rate   = cfg_one_q[VDP_POS_CLK_RATE +: 2];
    pin_irq_en   = cfg_two_q[VDP_POS_PIN_IRQ];
    det_in_rec   = cfg_two_q[VDP_POS_DET_REC];
    det_enable   = pwr_cfg_q[VDP_POS_DET_ENABLE];
  end

  // ----------------------------------------
  // Detector run
  // ----------------------------------------
  // Detector stops during recording unless allowed; gated by global enable
  always_comb begin
    run_d = det_enable
            && (!i_recording || det_in_rec);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // ----------------------------------------
  // Serial data pin interrupt
  // ----------------------------------------
  // Pin only carries the interrupt outside recording
  always_comb begin
    irq_pin_d = pin_irq_en && !i_recording
                && run_d && i_detector_irq;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      irq_pin_q <= 1'b0;
    end else begin
      irq_pin_q <= irq_pin_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    o_rd_data           = rd_data_q;
    o_page              = page_q;
    o_detector_run      = run_q;
    o_power_seq         = power_seq;
    o_channel_sel       = channel_sel;
    o_clock_source      = clock_source;
    o_clock_rate        = clock_rate;
    o_serial_out_irq    = irq_pin_q;
    o_serial_out_irq_en = pin_irq_en;
  end

endmodule

//--- sim/vdp_regs_props.sv
// Checker of the detector register slice ports
`timescale 1ns/1ps
module vdp_regs_props
  import vdp_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_recording,
  input wire logic       i_detector_irq,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_page,
  input wire logic       o_detector_run,
  input wire logic [1:0] o_power_seq,
  input wire logic [1:0] o_channel_sel,
  input wire logic [1:0] o_clock_source,
  input wire logic [1:0] o_clock_rate,
  input wire logic       o_serial_out_irq,
  input wire logic       o_serial_out_irq_en
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  wire logic       p1 = (o_page == VDP_PAGE_ONE);
  wire logic       w1 = i_wr_en && p1 && (i_addr == VDP_OFS_VD_CONFIG_1);
  wire logic [7:0] c1 = {o_power_seq, o_channel_sel, o_clock_source, o_clock_rate};
  a_page_load: assert property (i_wr_en && i_addr == 8'h00 |=> o_page == $past(i_wr_data))
    else $error("page not loaded");
  a_cfg1_load: assert property (w1 |=> c1 == $past(i_wr_data))
    else $error("config one not loaded");
  a_cfg1_keep: assert property (!w1 |=> $stable(c1))
    else $error("config one changed");
  a_pin_irq_en: assert property (i_wr_en && p1 && i_addr == 8'h1F |=>
    o_serial_out_irq_en == $past(i_wr_data[6])) else $error("pin irq enable wrong");
  a_irq_cause: assert property (o_serial_out_irq |-> $past(o_serial_out_irq_en) &&
    !$past(i_recording) && $past(i_detector_irq)) else $error("pin irq without cause");
  a_run_steady: assert property (!$past(i_wr_en) && $stable(i_recording) |=>
    $stable(o_detector_run)) else $error("run changed with no cause");
  a_read_page: assert property (i_rd_en && !i_wr_en && i_addr == 8'h00 |=>
    o_rd_data == $past(o_page)) else $error("page read wrong");
  a_read_cfg1: assert property (i_rd_en && !i_wr_en && p1 && i_addr == 8'h1E |=>
    o_rd_data == $past(c1)) else $error("config one read wrong");
  a_read_cfg2: assert property (i_rd_en && p1 && i_addr == 8'h1F |=>
    o_rd_data[5] == 1'b0 && o_rd_data[2:0] == 3'h0) else $error("read-only bits set");
  cover property (i_wr_en && p1 && i_addr == 8'h1F);
  cover property (o_serial_out_irq);
  cover property (o_detector_run && i_recording);
endmodule
bind vdp_regs vdp_regs_props i_props (
  .i_ref_clk           (i_ref_clk),
  .i_reset             (i_reset),
  .i_wr_en             (i_wr_en),
  .i_rd_en             (i_rd_en),
  .i_addr              (i_addr),
  .i_wr_data           (i_wr_data),
  .i_recording         (i_recording),
  .i_detector_irq      (i_detector_irq),
  .o_rd_data           (o_rd_data),
  .o_page              (o_page),
  .o_detector_run      (o_detector_run),
  .o_power_seq         (o_power_seq),
  .o_channel_sel       (o_channel_sel),
  .o_clock_source      (o_clock_source),
  .o_clock_rate        (o_clock_rate),
  .o_serial_out_irq    (o_serial_out_irq),
  .o_serial_out_irq_en (o_serial_out_irq_en)
);

//--- sim/vdp_host.sv
// Host controller model driving the register strobe port
`timescale 1ns/1ps
module vdp_host (
  input  wire logic       i_ref_clk,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wr_data
);
  initial {o_wr_en, o_rd_en, o_addr, o_wr_data} = 18'h0;
  // One-cycle strobe; idle lines show the inverse so stale values never pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    {o_wr_en, o_rd_en, o_addr, o_wr_data} = {w, !w, a, d};
    @(negedge i_ref_clk);
    {o_wr_en, o_rd_en, o_addr, o_wr_data} = {2'b00, ~a, ~d};
  endtask
endmodule

//--- sim/vdp_regs_tb.sv
// Self-checking bench for the detector register slice
`timescale 1ns/1ps
module vdp_regs_tb;
  import vdp_pkg::*;
  logic       clk, rst, rec, irq, we, re, sirq, sen, run;
  logic [7:0] adr, wd, rd, pg;
  logic [1:0] ps, cs, src, rt;
  logic [31:0] lf = 32'h219d_3a05;
  int num_errors = 0, cmp_count = 0, p = 0, c1 = 32, c2 = 8, pw = 0, ck = 0;
  vdp_host i_vdp_host (.i_ref_clk(clk), .o_wr_en(we), .o_rd_en(re), .o_addr(adr), .o_wr_data(wd));
  vdp_regs i_vdp_regs (.i_ref_clk(clk), .i_reset(rst), .i_wr_en(we), .i_rd_en(re), .i_addr(adr),
    .i_wr_data(wd), .i_recording(rec), .i_detector_irq(irq), .o_rd_data(rd), .o_page(pg),
    .o_detector_run(run), .o_power_seq(ps), .o_channel_sel(cs), .o_clock_source(src),
    .o_clock_rate(rt), .o_serial_out_irq(sirq), .o_serial_out_irq_en(sen));
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input int e, input string m);
    cmp_count++;
    if (got !== e[7:0]) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, e[7:0]);
    end
  endtask
  // Model uses the page held before the write, as the port does
  task automatic wr(input int a, input int d);
    i_vdp_host.xfer(1'b1, a[7:0], d[7:0]);
    ck = (p == 0 && a == 'h7e) ? d : (((ck << 1) | (ck >> 7)) & 255) ^ d;
    if (p == 1 && a == 'h1e) c1 = d;
    if (p == 1 && a == 'h1f) c2 = d & 'hd8;
    if (p == 0 && a == 'h75) pw = d;
    if (a == 0) p = d;
  endtask
  task automatic rdc(input int a, input int e);
    i_vdp_host.xfer(1'b0, a[7:0], 8'h00);
    chk(rd, e, "read");
  endtask
  task automatic test_done();
    $display("%0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst, rec, irq} = 3'b100;
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 0;
    rdc(0, 0);
    rdc('h7e, 0);
    wr(0, 1);
    rdc('h1e, 'h20);
    rdc('h1f, 8);
    rdc('h10, 0);
    $display("reset values done");
    for (int i = 0; i < 32; i++) begin
      wr('h1e, rnd());
      wr('h1f, rnd() & 'h48);
      chk({ps, cs, src, rt}, c1, "fields");
      chk({7'h0, sen}, c2 >> 6, "pin irq enable");
      rdc('h1f, c2);
      wr(0, rnd());
      chk(pg, p, "page");
      rdc(0, p);
      wr(0, 0);
      rdc('h7e, ck);
      wr('h7e, i);
      wr(0, 1);
    end
    $display("config and checksum done");
    wr(0, 0);
    for (int i = 0; i < 24; i++) begin
      {rec, irq} = 2'(rnd());
      if (i == 6) wr('h75, 1);
      if (i == 12) wr(0, 1);
      if (i == 13) wr('h1f, 'h48);
      if (i == 18) wr('h1f, 'h40);
      @(negedge clk);
      chk({7'h0, run}, pw & (!rec | (c2 >> 3)), "run");
      chk({7'h0, sirq}, (c2 >> 6) & !rec & pw & irq, "pin irq");
    end
    $display("detector run done");
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    p = 0;
    c1 = 32;
    c2 = 8;
    pw = 0;
    ck = 0;
    rdc(0, 0);
    rdc('h7e, ck);
    chk({ps, cs, src, rt}, c1, "reset fields");
    chk({7'h0, sen}, c2 >> 6, "reset pin irq enable");
    chk({7'h0, run}, pw, "reset run");
    wr(0, 1);
    rdc('h1f, c2);
    wr(0, 0);
    rdc('h7e, ck);
    $display("second reset done");
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("mismatch at %0t: timeout", $time);
    test_done();
  end
endmodule
